// ---- pprc_pkg.sv ----
// constants and types for the per-port protection and charge quota controller
// Operation
// R1: stage1 overtemp in CC mode opens that port
// R2: stage1 overtemp during overcurrent mask opens immediately
// R3: stage1 hot refuses enable edge or power-up close
// R4: stage1 error held until below hysteresis
// R5: stage2 overtemp opens both ports, both error
// R6: stage2 error held until below hysteresis
// R7: auto discharge on five listed events
// R8: discharge check failure sets flag and error
// R9: manual discharge follows bit, no timer
// R10: host times and clears manual discharge bit
// R11: quota counts only in Active state
// R12: action change keeps charge, silent before threshold
// R13: action change after threshold applies immediately
// R14: action codes: alert, alert+open, open+sleep, none
// R15: alert+open keeps monitoring, switch held open
// R16: open+sleep stops monitoring, ignores enable toggles
// R17: quota reset clears charge, flag, alert, reapplies enable
// R18: quota clear zeroes charge, accumulation restarts
// R19: alert held while any cause remains
package pprc_pkg;
  localparam logic [1:0] QA_ALERT = 2'h0;
  localparam logic [1:0] QA_ALERT_OPEN = 2'h1;
  localparam logic [1:0] QA_OPEN_SLEEP = 2'h2;
  localparam logic [1:0] QA_NONE = 2'h3;
  localparam logic [1:0] QA_RESET = QA_ALERT_OPEN;
  localparam int CLK_HZ = 20000000;
  localparam int DISCHARGE_TIME_US = 200;
  localparam int DISCHARGE_CYC = DISCHARGE_TIME_US * (CLK_HZ / 1000000);
  localparam int QUOTA_W = 24;
  localparam int DCNT_W = 16;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_SLEEP = 4'h4,
    ST_ERROR = 4'h8
  } pprc_state_e;
endpackage : pprc_pkg

// ---- pprc_ctrl.sv ----
// per-port thermal, discharge and charge quota control for two ports
`timescale 1ns/10ps
module pprc_ctrl #(
  parameter int DISCHARGE_CYCLES = pprc_pkg::DISCHARGE_CYC,
  parameter int QW = pprc_pkg::QUOTA_W
) (
  input wire logic CLK, // 20 MHz clock
  input wire logic RST_N, // sync reset, active low
  input wire logic [1:0] PORT_POWER_ENABLE, // bit0 port1, bit1 port2
  input wire logic THERMAL_STAGE1_HOT, // die above stage1 limit
  input wire logic THERMAL_STAGE1_COOL, // die below stage1 limit minus hysteresis
  input wire logic THERMAL_STAGE2_HOT, // die above stage2 limit
  input wire logic THERMAL_STAGE2_COOL, // die below stage2 limit minus hysteresis
  input wire logic [1:0] CC_MODE, // switch in constant current mode
  input wire logic [1:0] OVERCURRENT_MASK, // overcurrent mask time running
  input wire logic [1:0] SUPPLY_UNDERVOLTAGE, // supply below undervoltage limit
  input wire logic [1:0] SLEEP_CMD, // pulse: command sleep
  input wire logic [1:0] DISCHARGE_CMD, // pulse: bus discharge command
  input wire logic [1:0] VBUS_DISCHARGED, // vbus below discharge-done level
  input wire logic AUTO_DISCHARGE_ENABLE, // automatic discharge enable
  input wire logic [1:0] MANUAL_DISCHARGE, // manual discharge bits
  input wire logic [3:0] CHARGE_QUOTA_ACTION, // [1:0] port1, [3:2] port2
  input wire logic [1:0] CHARGE_INC, // pulse: one charge unit delivered
  input wire logic [2*QW-1:0] QUOTA_THRESHOLD, // per-port threshold
  input wire logic [1:0] CHARGE_QUOTA_CLEAR, // pulse: clear quota
  output logic [1:0] SWITCH_CLOSE, // port switch closed
  output logic [1:0] DISCHARGE_LOAD, // discharge load connected
  output logic [1:0] ALERT_N, // alert outputs, active low
  output logic [1:0] PORT_ERROR, // channel in error
  output logic [1:0] PORT_SLEEP, // channel in sleep
  output logic [1:0] MONITOR_ENABLE, // bus and supply monitoring on
  output logic [1:0] DISCHARGE_ERROR_FLAG, // discharge check failed
  output logic [1:0] CHARGE_QUOTA_HIT_FLAG, // threshold reached
  output logic [2*QW-1:0] CHARGE_TOTAL // accumulated charge per port
);
  logic stage2_ff;
  logic [1:0] stage1_ff;
  logic powered_ff;

  // stage2 hold covers both ports until cooled
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stage2_ff <= 1'b0;
      powered_ff <= 1'b0;
    end else begin
      powered_ff <= 1'b1;
      if (THERMAL_STAGE2_HOT) begin
        stage2_ff <= 1'b1; // see R5
      end else if (THERMAL_STAGE2_COOL) begin
        stage2_ff <= 1'b0; // see R6
      end
    end
  end

  // stage1 hot and not yet recovered
  logic stage1_warm_ff;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stage1_warm_ff <= 1'b0;
    end else if (THERMAL_STAGE1_HOT) begin
      stage1_warm_ff <= 1'b1;
    end else if (THERMAL_STAGE1_COOL) begin
      stage1_warm_ff <= 1'b0;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      pprc_pkg::pprc_state_e state_ff, nxt_state;
      logic en_ff;
      logic first_ff;
      logic err_t1_ff;
      logic disch_ff;
      logic [pprc_pkg::DCNT_W-1:0] dcnt_ff;
      logic derr_ff;
      logic hit_ff;
      logic [QW-1:0] total_ff;
      logic [1:0] act;
      logic en_rise, en_fall, t1_trip, t1_refuse, uv_trip;
      logic quota_clr, hold_open, hold_sleep, alert_quota;
      logic auto_start, disch_done, disch_fail, recover;
      logic [QW-1:0] thr;

      assign act = CHARGE_QUOTA_ACTION[2*p +: 2];
      assign thr = QUOTA_THRESHOLD[QW*p +: QW];
      assign en_rise = PORT_POWER_ENABLE[p] & ~en_ff;
      assign en_fall = ~PORT_POWER_ENABLE[p] & en_ff;
      // trip at once even while the overcurrent mask runs
      assign t1_trip = THERMAL_STAGE1_HOT & (CC_MODE[p] | OVERCURRENT_MASK[p])
                       & (state_ff == pprc_pkg::ST_ACTIVE); // see R1, R2
      assign t1_refuse = stage1_warm_ff & PORT_POWER_ENABLE[p]
                         & (en_rise | first_ff); // see R3
      assign uv_trip = SUPPLY_UNDERVOLTAGE[p] & (state_ff == pprc_pkg::ST_ACTIVE);
      assign quota_clr = CHARGE_QUOTA_CLEAR[p];
      // quota effects are read live so action changes apply at once
      assign hold_open = hit_ff & (act == pprc_pkg::QA_ALERT_OPEN); // see R13, R15
      assign hold_sleep = hit_ff & (act == pprc_pkg::QA_OPEN_SLEEP); // see R13, R16
      assign alert_quota = hit_ff & ((act == pprc_pkg::QA_ALERT)
                           | (act == pprc_pkg::QA_ALERT_OPEN)); // see R14
      assign recover = (state_ff == pprc_pkg::ST_ERROR) & ~stage2_ff & ~stage1_warm_ff
                       & ~err_t1_ff & ~derr_ff;
      assign auto_start = AUTO_DISCHARGE_ENABLE & ~disch_ff & (en_fall | uv_trip
                          | (SLEEP_CMD[p] & state_ff != pprc_pkg::ST_SLEEP)
                          | recover
                          | (DISCHARGE_CMD[p] & state_ff == pprc_pkg::ST_ACTIVE)); // see R7
      assign disch_done = disch_ff & (dcnt_ff == pprc_pkg::DCNT_W'(DISCHARGE_CYCLES - 1));
      assign disch_fail = disch_done & ~VBUS_DISCHARGED[p]; // see R8

      always_comb begin
        nxt_state = state_ff;
        case (state_ff)
          pprc_pkg::ST_OFF: begin
            if (PORT_POWER_ENABLE[p] & ~hold_sleep) begin
              nxt_state = pprc_pkg::ST_ACTIVE;
            end
          end
          pprc_pkg::ST_ACTIVE: begin
            if (!PORT_POWER_ENABLE[p]) begin
              nxt_state = pprc_pkg::ST_OFF;
            end else if (SLEEP_CMD[p]) begin
              nxt_state = pprc_pkg::ST_SLEEP;
            end
          end
          pprc_pkg::ST_SLEEP: begin
            // enable toggles ignored while quota sleep holds
            if (!hold_sleep & PORT_POWER_ENABLE[p] & ~SLEEP_CMD[p]) begin
              nxt_state = pprc_pkg::ST_ACTIVE; // see R16, R17
            end
          end
          pprc_pkg::ST_ERROR: begin
            if (recover) begin
              nxt_state = PORT_POWER_ENABLE[p] ? pprc_pkg::ST_ACTIVE : pprc_pkg::ST_OFF; // see R4
            end
          end
          default: nxt_state = pprc_pkg::ST_OFF;
        endcase
        if (hold_sleep & state_ff != pprc_pkg::ST_ERROR) begin
          nxt_state = pprc_pkg::ST_SLEEP;
        end
        if (stage2_ff | t1_trip | t1_refuse | disch_fail | uv_trip) begin
          nxt_state = pprc_pkg::ST_ERROR; // see R5
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          state_ff <= pprc_pkg::ST_OFF;
          en_ff <= 1'b0;
          first_ff <= 1'b1;
          err_t1_ff <= 1'b0;
        end else begin
          state_ff <= nxt_state;
          en_ff <= PORT_POWER_ENABLE[p];
          first_ff <= ~powered_ff;
          if (t1_trip | t1_refuse) begin
            err_t1_ff <= 1'b1; // see R1, R3
          end else if (~stage1_warm_ff) begin
            err_t1_ff <= 1'b0; // see R4
          end
        end
      end

      // automatic discharge timer and check
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          disch_ff <= 1'b0;
          dcnt_ff <= '0;
          derr_ff <= 1'b0;
        end else begin
          if (auto_start) begin
            disch_ff <= 1'b1;
            dcnt_ff <= '0;
          end else if (disch_done) begin
            disch_ff <= 1'b0;
          end else if (disch_ff) begin
            dcnt_ff <= dcnt_ff + 1'b1;
          end
          // set wins over the clear on an enable edge
          if (disch_fail) begin
            derr_ff <= 1'b1; // see R8
          end else if (en_rise) begin
            derr_ff <= 1'b0;
          end
        end
      end

      // quota accounting, active state only
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          total_ff <= '0;
          hit_ff <= 1'b0;
        end else begin
          if (quota_clr) begin
            total_ff <= '0; // see R17, R18
            hit_ff <= 1'b0; // see R17
          end else begin
            // action field never touches the count
            if (CHARGE_INC[p] & (state_ff == pprc_pkg::ST_ACTIVE) & ~hit_ff) begin
              total_ff <= total_ff + 1'b1; // see R11, R12
            end
            if (state_ff == pprc_pkg::ST_ACTIVE & total_ff >= thr & thr != '0) begin
              hit_ff <= 1'b1; // see R11
            end
          end
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          SWITCH_CLOSE[p] <= 1'b0;
          DISCHARGE_LOAD[p] <= 1'b0;
          ALERT_N[p] <= 1'b1;
          PORT_ERROR[p] <= 1'b0;
          PORT_SLEEP[p] <= 1'b0;
          MONITOR_ENABLE[p] <= 1'b0;
        end else begin
          SWITCH_CLOSE[p] <= (nxt_state == pprc_pkg::ST_ACTIVE) & ~hold_open & ~hold_sleep;
          // manual load follows the bit only while auto is off
          DISCHARGE_LOAD[p] <= AUTO_DISCHARGE_ENABLE ? (disch_ff & ~disch_done)
                               : MANUAL_DISCHARGE[p]; // see R9, R10
          // released only when every cause is gone
          ALERT_N[p] <= ~((nxt_state == pprc_pkg::ST_ERROR) | alert_quota
                          | derr_ff | disch_fail); // see R19
          PORT_ERROR[p] <= nxt_state == pprc_pkg::ST_ERROR;
          PORT_SLEEP[p] <= nxt_state == pprc_pkg::ST_SLEEP;
          MONITOR_ENABLE[p] <= ~hold_sleep; // see R16
        end
      end

      assign DISCHARGE_ERROR_FLAG[p] = derr_ff;
      assign CHARGE_QUOTA_HIT_FLAG[p] = hit_ff;
      assign CHARGE_TOTAL[QW*p +: QW] = total_ff;
    end
  endgenerate
endmodule : pprc_ctrl

// ---- pprc_ctrl_sva.sv ----
// port assertions for the protection controller
`timescale 1ns/10ps
module pprc_ctrl_sva #(
  parameter int QW = 24
) (
  input wire logic CLK, // clock
  input wire logic RST_N, // reset
  input wire logic [1:0] PORT_POWER_ENABLE, // enables
  input wire logic THERMAL_STAGE1_HOT, // hot1
  input wire logic THERMAL_STAGE2_HOT, // hot2
  input wire logic THERMAL_STAGE2_COOL, // cool2
  input wire logic [1:0] CC_MODE, // cc
  input wire logic [1:0] OVERCURRENT_MASK, // mask
  input wire logic AUTO_DISCHARGE_ENABLE, // auto
  input wire logic [1:0] MANUAL_DISCHARGE, // manual
  input wire logic [3:0] CHARGE_QUOTA_ACTION, // action
  input wire logic [1:0] CHARGE_QUOTA_CLEAR, // clear
  input wire logic [1:0] SWITCH_CLOSE, // switch
  input wire logic [1:0] DISCHARGE_LOAD, // load
  input wire logic [1:0] ALERT_N, // alert
  input wire logic [1:0] PORT_ERROR, // error
  input wire logic [1:0] CHARGE_QUOTA_HIT_FLAG, // hit
  input wire logic [2*QW-1:0] CHARGE_TOTAL, // total
  input wire logic [2*QW-1:0] QUOTA_THRESHOLD // per-port threshold
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire [1:0] act0 = CHARGE_QUOTA_ACTION[1:0];
  // hot is registered once before it reaches the next-state logic
  a_stage2_open: assert property (THERMAL_STAGE2_HOT |-> ##2 SWITCH_CLOSE == 2'h0
    && PORT_ERROR == 2'h3 && ALERT_N == 2'h0) else $error("stage2 trip missed");
  a_stage2_hold: assert property (THERMAL_STAGE2_HOT ##1 !THERMAL_STAGE2_COOL [*2]
    |=> PORT_ERROR == 2'h3) else $error("stage2 error dropped");
  a_cc_trip: assert property (THERMAL_STAGE1_HOT && SWITCH_CLOSE[0] && CC_MODE[0]
    |=> !SWITCH_CLOSE[0] && PORT_ERROR[0] && !ALERT_N[0]) else $error("cc trip missed");
  a_mask_trip: assert property (THERMAL_STAGE1_HOT && SWITCH_CLOSE[1] && OVERCURRENT_MASK[1]
    |=> !SWITCH_CLOSE[1]) else $error("mask trip missed");
  a_warm_refuse: assert property ($rose(PORT_POWER_ENABLE[1]) && THERMAL_STAGE1_HOT
    && $past(THERMAL_STAGE1_HOT)
    |=> !SWITCH_CLOSE[1] && PORT_ERROR[1]) else $error("hot close allowed");
  a_manual_load: assert property (!AUTO_DISCHARGE_ENABLE ##1 !AUTO_DISCHARGE_ENABLE
    |-> DISCHARGE_LOAD == $past(MANUAL_DISCHARGE)) else $error("manual load wrong");
  // one cycle of latency after any action change, hence the stable guard
  a_quota_act: assert property (CHARGE_QUOTA_HIT_FLAG[0] && $past(CHARGE_QUOTA_HIT_FLAG[0])
    && $stable(act0) && !PORT_ERROR[0] |-> ALERT_N[0] == act0[1]
    && (act0[0] == act0[1] || !SWITCH_CLOSE[0])) else $error("quota action wrong");
  a_clear_zero: assert property (CHARGE_QUOTA_CLEAR[0] |=> !CHARGE_QUOTA_HIT_FLAG[0]
    && CHARGE_TOTAL[QW-1:0] == {QW{1'h0}}) else $error("quota clear failed");
  c_hit: cover property (CHARGE_QUOTA_HIT_FLAG[0]);
  c_stage2: cover property (THERMAL_STAGE2_HOT);
  c_load: cover property (DISCHARGE_LOAD == 2'h3);
  c_refuse: cover property ($rose(PORT_POWER_ENABLE[1]) && PORT_ERROR[1]);
endmodule : pprc_ctrl_sva
bind pprc_ctrl pprc_ctrl_sva #(.QW(QW)) pprc_ctrl_sva_inst (.*);

// ---- pprc_host_model.sv ----
// host model that times manual discharges itself
`timescale 1ns/10ps
module pprc_host_model #(
  parameter int HOLD = 6
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [1:0] start, // begin discharge
  output logic [1:0] man_dis // manual bits
);
  int cnt [2];
  assign man_dis = {cnt[1] != 0, cnt[0] != 0};
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (!rst_n) cnt[p] <= 0;
      else if (start[p]) cnt[p] <= HOLD;
      else if (cnt[p] > 0) cnt[p] <= cnt[p] - 1; // host clears the bit
    end
  end
endmodule : pprc_host_model

// ---- pprc_ctrl_bench.sv ----
// self-checking bench for the protection controller
`timescale 1ns/10ps
module pprc_ctrl_bench;
  logic clk = 1'h0, rst_n = 1'h0, s1h = 1'h0, s1c = 1'h1, s2h = 1'h0, s2c = 1'h1, auto = 1'h0;
  logic [1:0] en = 2'h0, cc = 2'h0, ocm = 2'h0, tie = 2'h0, vdis = 2'h3, inc = 2'h0;
  logic [1:0] clr = 2'h0, go = 2'h0, man, sw, load, alert_n, err, sleep, dflag, hit;
  logic [1:0] slp = 2'h0, dcmd = 2'h0, mon;
  logic [3:0] act = 4'h5;
  logic [47:0] thr = 48'h000000000003, tot;
  int fail_count = 0, compares = 0, cyc = 0;
  always #25 clk = ~clk;
  pprc_ctrl #(.DISCHARGE_CYCLES(8)) pprc_ctrl_inst (.CLK(clk), .RST_N(rst_n),
    .PORT_POWER_ENABLE(en), .THERMAL_STAGE1_HOT(s1h), .THERMAL_STAGE1_COOL(s1c),
    .THERMAL_STAGE2_HOT(s2h), .THERMAL_STAGE2_COOL(s2c), .CC_MODE(cc), .OVERCURRENT_MASK(ocm),
    .SUPPLY_UNDERVOLTAGE(tie), .SLEEP_CMD(slp), .DISCHARGE_CMD(dcmd), .VBUS_DISCHARGED(vdis),
    .AUTO_DISCHARGE_ENABLE(auto), .MANUAL_DISCHARGE(man), .CHARGE_QUOTA_ACTION(act),
    .CHARGE_INC(inc), .QUOTA_THRESHOLD(thr), .CHARGE_QUOTA_CLEAR(clr), .SWITCH_CLOSE(sw),
    .DISCHARGE_LOAD(load), .ALERT_N(alert_n), .PORT_ERROR(err), .PORT_SLEEP(sleep),
    .MONITOR_ENABLE(mon), .DISCHARGE_ERROR_FLAG(dflag), .CHARGE_QUOTA_HIT_FLAG(hit),
    .CHARGE_TOTAL(tot));
  pprc_host_model pprc_host_model_inst (.clk(clk), .rst_n(rst_n), .start(go), .man_dis(man));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // a hang costs one mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    tick(3);
    chk({sw, alert_n, err, load}, 8'h30);
    rst_n = 1'h1;
    en = 2'h3;
    tick(3);
    for (int c = 0; c < 4; c++) begin
      inc = 2'h1;
      tick(1);
      act[1:0] = c[1:0]; // change before threshold stays silent
      tick(2);
      inc = 2'h0;
      tick(3);
      chk({hit[0], tot[23:0]}, 25'h1000003);
      chk({alert_n[0], sw[0], sleep[0]}, {c[1], c[0] == c[1], c == 2});
      chk(mon[0], c != 2);
      if (c == 3) begin
        act[1:0] = 2'h1;
        tick(2);
        chk({alert_n[0], sw[0]}, 2'h0);
      end
      clr = 2'h1;
      tick(1);
      clr = 2'h0;
      tick(3);
      chk({hit[0], alert_n[0], sw[0], tot[23:0]}, 27'h3000000);
    end
    cc = 2'h1;
    s1h = 1'h1;
    s1c = 1'h0;
    tick(2);
    chk({sw, err, alert_n}, 6'h26);
    en = 2'h1;
    inc = 2'h1;
    tick(1);
    en = 2'h3;
    inc = 2'h0;
    tick(2);
    chk({sw, err, alert_n}, 6'h0C);
    s1h = 1'h0;
    cc = 2'h0;
    tick(4);
    chk({sw, err}, 4'h3);
    s1c = 1'h1;
    tick(4);
    chk({err, alert_n}, 4'h3);
    s2h = 1'h1;
    s2c = 1'h0;
    s1h = 1'h1;
    ocm = 2'h2;
    tick(2);
    chk({sw, err, alert_n}, 6'h0C);
    s2h = 1'h0;
    s1h = 1'h0;
    ocm = 2'h0;
    tick(4);
    chk(err, 2'h3);
    s2c = 1'h1;
    tick(4);
    chk({err, alert_n}, 4'h3);
    go = 2'h1;
    tick(1);
    go = 2'h0;
    tick(2);
    chk(load, 2'h1);
    tick(6);
    chk(load, 2'h0);
    auto = 1'h1;
    dcmd = 2'h2;
    tick(1);
    dcmd = 2'h0;
    tick(1);
    chk(load, 2'h2);
    tick(8);
    slp = 2'h2;
    tick(1);
    slp = 2'h0;
    tick(1);
    chk(load, 2'h2);
    tick(8);
    vdis = 2'h2;
    en = 2'h0;
    tick(2);
    chk(load, 2'h3);
    tick(11);
    chk({dflag, err[0]}, 3'h3);
    final_report();
  end
endmodule : pprc_ctrl_bench
